// ===== tb/bdec_ctrl_tb_top.sv
// Purpose: self-checking bench of the brake, direction and encoder control
// Assumes: clock enable held high except in the frozen-write check, one request at a time through the master model
// Notes:   table rows cover register access; hand tests cover gating and restart
`timescale 1ns/1ns
module bdec_ctrl_tb_top
  import bdec_pkg::*;
();
  typedef struct packed {
    logic wr; logic [15:0] addr; logic [15:0] data; logic err; logic [31:0] rdata; logic brk;
  } bdec_row_t;
  localparam bdec_row_t ROWS [13] = '{
    '{1'h0, 16'h0814, 16'h0000, 1'h0, 32'h0, 1'h0}, '{1'h0, 16'h0618, 16'h0000, 1'h0, 32'h0, 1'h0},
    '{1'h1, 16'h0814, 16'h0003, 1'h1, 32'h0, 1'h0}, '{1'h1, 16'h0814, 16'h0001, 1'h0, 32'h0, 1'h1},
    '{1'h0, 16'h0814, 16'h0000, 1'h0, 32'h1, 1'h1}, '{1'h1, 16'h0814, 16'h0002, 1'h0, 32'h0, 1'h0},
    '{1'h1, 16'h0814, 16'h0001, 1'h1, 32'h0, 1'h0}, '{1'h1, 16'h0814, 16'h0000, 1'h0, 32'h0, 1'h0},
    '{1'h1, 16'h0618, 16'h0002, 1'h1, 32'h0, 1'h0}, '{1'h1, 16'h0618, 16'h0001, 1'h0, 32'h0, 1'h0},
    '{1'h0, 16'h0618, 16'h0000, 1'h0, 32'h1, 1'h0}, '{1'h1, 16'h1E1E, 16'h0000, 1'h1, 32'h0, 1'h0},
    '{1'h0, 16'h0100, 16'h0000, 1'h1, 32'h0, 1'h0}};

  logic                       clk_i, rst_b_i, ce, power_on, stage_en, auto_rel, target_neg;
  logic                       enc_valid, enc_mt, gear, brk, mv_pos, inv_act, abs_valid;
  logic [3:0]                 op_state;
  logic [NUM_DI-1:0]          di;
  bdec_di_func_t [NUM_DI-1:0] di_func;
  logic [ENC_MT_W-1:0]        enc_pos;
  bdec_param_req_t            req;
  bdec_param_rsp_t            rsp, got;
  bdec_jog_t                  jog;
  int                         n_errors, samples_checked;

  bdec_master_model u_master (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));

  bdec_ctrl u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .req_i(req), .rsp_o(rsp),
    .op_state_i(op_state), .stage_enabled_i(stage_en), .auto_release_i(auto_rel),
    .power_on_i(power_on), .target_neg_i(target_neg), .di_i(di), .di_func_i(di_func),
    .enc_pos_i(enc_pos), .enc_valid_i(enc_valid), .enc_multiturn_i(enc_mt),
    .gear_change_i(gear), .brake_release_o(brk), .move_positive_o(mv_pos),
    .invert_active_o(inv_act), .jog_o(jog), .abs_valid_o(abs_valid));

  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    complete_run();
  end

  initial begin
    {rst_b_i, power_on, stage_en, auto_rel, target_neg, enc_valid, enc_mt, gear} = '0;
    ce = 1'h1;
    op_state = OPST_SWITCH_ON_DIS;
    di = '0;
    di_func = '{default: DIF_NONE};
    enc_pos = 29'h0ABCDEF1;
    n_errors = 0;
    samples_checked = 0;
    tick(5);
    rst_b_i = 1'h1;
    tick(1);
    chk("brake_out", brk, 32'h0);
    foreach (ROWS[i]) begin
      u_master.access(ROWS[i].wr, ROWS[i].addr, ROWS[i].data, got);
      tick(2);
      chk("ack", got.ack, 32'h1);
      chk("err", got.err, ROWS[i].err);
      chk("rdata", got.rdata, ROWS[i].rdata);
      chk("brake_out", brk, ROWS[i].brk);
    end
    di_func[0] = DIF_RELEASE_BRAKE;
    di[0] = 1'h1;
    tick(5);
    chk("brake_di", brk, 32'h1);
    di_func[0] = DIF_NONE;
    tick(2);
    chk("brake_di", brk, 32'h0);
    di[0] = 1'h0;
    u_master.set_brake(2'h1, got);
    tick(2);
    chk("brake_rel", brk, 32'h1);
    op_state = 4'h6;
    tick(2);
    chk("brake_rel", brk, 32'h0);
    op_state = OPST_FAULT;
    tick(2);
    chk("brake_rel", brk, 32'h1);
    op_state = OPST_READY_TO_SW;
    u_master.set_brake(2'h2, got);
    auto_rel = 1'h1;
    stage_en = 1'h1;
    tick(2);
    chk("brake_apply", brk, 32'h0);
    u_master.set_brake(2'h1, got);
    tick(2);
    chk("err", got.err, 32'h0);
    chk("brake_rel", brk, 32'h1);
    // clock enable low: a write and the brake output must both be frozen
    ce = 1'h0;
    u_master.access(1'h1, ADDR_BRAKE_CTRL, 16'h0002, got);
    tick(2);
    chk("ack_frozen", got.ack, 32'h0);
    chk("brake_frozen", brk, 32'h1);
    ce = 1'h1;
    auto_rel = 1'h0;
    u_master.access(1'h1, ADDR_INVERT_CFG, 16'h0000, got);
    chk("err", got.err, 32'h1);
    target_neg = 1'h1;
    tick(2);
    chk("invert", inv_act, 32'h0);
    chk("move_pos", mv_pos, 32'h0);
    enc_valid = 1'h1;
    tick(3);
    chk("abs_valid", abs_valid, 32'h1);
    u_master.access(1'h0, ADDR_ENC_ABSPOS, 16'h0000, got);
    chk("abs_pos", got.rdata, 32'(enc_pos % ENC_ST_INCR));
    gear = 1'h1;
    tick(1);
    gear = 1'h0;
    tick(1);
    chk("abs_valid", abs_valid, 32'h0);
    enc_mt = 1'h1;
    stage_en = 1'h0;
    power_on = 1'h1;
    tick(1);
    power_on = 1'h0;
    tick(4);
    chk("invert", inv_act, 32'h1);
    chk("move_pos", mv_pos, 32'h1);
    chk("abs_valid", abs_valid, 32'h1);
    u_master.access(1'h0, ADDR_ENC_ABSPOS, 16'h0000, got);
    chk("abs_pos", got.rdata, 32'(enc_pos % (ENC_ST_INCR * ENC_MT_REVS)));
    di_func[1] = DIF_JOG_POS_EN;
    di[1] = 1'h1;
    tick(4);
    chk("jog", jog, 32'hD);
    di[1] = 1'h0;
    di_func[2] = DIF_JOG_NEG_EN;
    di[2] = 1'h1;
    tick(4);
    chk("jog", jog, 32'hB);
    // mid-run reset clears outputs and stored settings
    rst_b_i = 1'h0;
    tick(2);
    chk("brake_rst", brk, 32'h0);
    chk("invert_rst", inv_act, 32'h0);
    chk("valid_rst", abs_valid, 32'h0);
    chk("jog_rst", jog, 32'h0);
    rst_b_i = 1'h1;
    u_master.access(1'h0, ADDR_BRAKE_CTRL, 16'h0000, got);
    chk("rdata_rst", got.rdata, 32'h0);
    u_master.access(1'h0, ADDR_INVERT_CFG, 16'h0000, got);
    chk("rdata_rst", got.rdata, 32'h0);
    complete_run();
  end
endmodule

// ===== tb/bdec_master_model.sv
// Purpose: fieldbus master on the parameter interface of the brake/direction/encoder block
// Assumes: one-cycle requests, answer registered on the same edge that takes the request
// Notes:   released address and data lines show the inverse of their last value
`timescale 1ns/1ns
module bdec_master_model
  import bdec_pkg::*;
(
  // clock
  input  wire logic            clk_i,
  // parameter interface
  input  wire bdec_param_rsp_t rsp_i,
  output bdec_param_req_t      req_o
);
  logic [1:0] last_brk;

  initial begin
    req_o    = '0;
    last_brk = 2'h0;
  end

  // one request cycle, answer taken just after the edge that accepted it
  task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
                        input logic [WDATA_W-1:0] data, output bdec_param_rsp_t rsp);
    @(posedge clk_i);
    #1;
    req_o = '{wr: wr, rd: !wr, addr: addr, wdata: data};
    @(posedge clk_i);
    #1;
    req_o = '{wr: 1'h0, rd: 1'h0, addr: ~addr, wdata: ~data};
    rsp   = rsp_i;
  endtask

  task automatic set_brake(input logic [1:0] v, output bdec_param_rsp_t rsp);
    if (last_brk == 2'h2 && v == 2'h1) access(1'h1, ADDR_BRAKE_CTRL, 16'h0000, rsp);
    access(1'h1, ADDR_BRAKE_CTRL, {14'h0000, v}, rsp);
    if (!rsp.err) last_brk = v;
  endtask
endmodule

// ===== verilog/bdec_ctrl.sv
// Purpose: brake manual control, direction inversion and absolute encoder capture
// Assumes: operating state, power stage and encoder inputs are on clk_i; di_i are pins
// Notes:   power_on_i marks a restart; inversion and position validity follow it
`timescale 1ns/1ns
module bdec_ctrl
  import bdec_pkg::*;
(
  // clock, reset, enable
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   ce_i,
  // parameter interface
  input  wire bdec_param_req_t        req_i,
  output bdec_param_rsp_t             rsp_o,
  // drive state
  input  wire logic [3:0]             op_state_i,
  input  wire logic                   stage_enabled_i,
  input  wire logic                   auto_release_i,
  input  wire logic                   power_on_i,
  input  wire logic                   target_neg_i,
  // digital inputs and their functions
  input  wire logic [NUM_DI-1:0]      di_i,
  input  wire bdec_di_func_t [NUM_DI-1:0] di_func_i,
  // encoder
  input  wire logic [ENC_MT_W-1:0]    enc_pos_i,
  input  wire logic                   enc_valid_i,
  input  wire logic                   enc_multiturn_i,
  input  wire logic                   gear_change_i,
  // control outputs
  output logic                        brake_release_o,
  output logic                        move_positive_o,
  output logic                        invert_active_o,
  output bdec_jog_t                   jog_o,
  output logic                        abs_valid_o
);

  typedef enum logic {
    ENC_WAIT,
    ENC_RUN
  } bdec_enc_state_t;

  bdec_brake_mode_t       brake_mode_reg;
  logic                   invert_cfg_reg;
  logic [NUM_DI-1:0]      di_meta_reg;
  logic [NUM_DI-1:0]      di_sync_reg;
  bdec_enc_state_t        enc_state_reg;
  logic [ENC_MT_W-1:0]    abs_pos_reg;
  logic                   rel_allowed;
  logic                   di_release;
  logic                   jog_pos_in;
  logic                   jog_neg_in;
  logic                   wr_brake_ok;
  logic                   wr_inv_ok;
  logic                   rd_hit;
  logic [ENC_MT_W-1:0]    pos_mod;

  function automatic logic di_func_hit(input logic [NUM_DI-1:0] lvl,
                                       input bdec_di_func_t [NUM_DI-1:0] fn,
                                       input bdec_di_func_t want);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (lvl[i] && fn[i] == want) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      di_meta_reg <= '0;
      di_sync_reg <= '0;
    end else if (ce_i) begin
      di_meta_reg <= di_i;
      di_sync_reg <= di_meta_reg;
    end
  end

  always_comb begin
    rel_allowed = (op_state_i == OPST_SWITCH_ON_DIS) || (op_state_i == OPST_READY_TO_SW) ||
                  (op_state_i == OPST_FAULT);
    di_release = di_func_hit(di_sync_reg, di_func_i, DIF_RELEASE_BRAKE);
    jog_pos_in = di_func_hit(di_sync_reg, di_func_i, DIF_JOG_POS_EN);
    jog_neg_in = di_func_hit(di_sync_reg, di_func_i, DIF_JOG_NEG_EN);
    wr_brake_ok = req_i.wr && req_i.addr == ADDR_BRAKE_CTRL && req_i.wdata <= BRAKE_MAX &&
                  !(brake_mode_reg == BRK_APPLY && req_i.wdata == WDATA_W'(BRAKE_MANUAL_CONTROL));
    wr_inv_ok = req_i.wr && req_i.addr == ADDR_INVERT_CFG && req_i.wdata <= INVERT_MAX &&
                !stage_enabled_i;
    rd_hit = req_i.addr == ADDR_BRAKE_CTRL || req_i.addr == ADDR_INVERT_CFG ||
             req_i.addr == ADDR_ENC_ABSPOS;
    pos_mod = enc_multiturn_i ? enc_pos_i : {{(ENC_MT_W-ENC_ST_W){1'b0}}, enc_pos_i[ENC_ST_W-1:0]};
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      brake_mode_reg <= BRK_AUTO;
    end else if (ce_i && wr_brake_ok) begin
      brake_mode_reg <= bdec_brake_mode_t'(req_i.wdata[1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      invert_cfg_reg <= 1'b0;
    end else if (ce_i && wr_inv_ok) begin
      invert_cfg_reg <= req_i.wdata[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      invert_active_o <= 1'b0;
    end else if (ce_i && power_on_i) begin
      invert_active_o <= invert_cfg_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      move_positive_o <= 1'b0;
    end else if (ce_i) begin
      move_positive_o <= target_neg_i ~^ invert_active_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      brake_release_o <= 1'b0;
    end else if (ce_i) begin
      case (brake_mode_reg)
        BRK_APPLY:   brake_release_o <= 1'b0;
        BRAKE_MANUAL_CONTROL: brake_release_o <= rel_allowed || auto_release_i;
        BRK_AUTO:    brake_release_o <= (di_release && rel_allowed) || auto_release_i;
        default:     brake_release_o <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      jog_o <= '0;
    end else if (ce_i) begin
      jog_o.jog_pos <= jog_pos_in && !jog_neg_in;
      jog_o.jog_neg <= jog_neg_in && !jog_pos_in;
      jog_o.jog_active <= jog_pos_in ^ jog_neg_in;
      jog_o.stage_enable_req <= jog_pos_in ^ jog_neg_in;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      enc_state_reg <= ENC_WAIT;
      abs_pos_reg <= '0;
      abs_valid_o <= 1'b0;
    end else if (ce_i) begin
      case (enc_state_reg)
        ENC_WAIT: begin
          // gear change before capture stays invalid
          if (gear_change_i) begin
            abs_valid_o <= 1'b0;
            enc_state_reg <= ENC_RUN;
          end else if (enc_valid_i) begin
            abs_pos_reg <= pos_mod;
            abs_valid_o <= 1'b1;
            enc_state_reg <= ENC_RUN;
          end
        end
        ENC_RUN: begin
          if (power_on_i) begin
            abs_valid_o <= 1'b0;
            enc_state_reg <= ENC_WAIT;
          end else if (gear_change_i) begin
            abs_valid_o <= 1'b0;
          end
        end
        default: enc_state_reg <= ENC_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rsp_o <= '0;
    end else if (ce_i) begin
      rsp_o.ack <= req_i.wr || req_i.rd;
      rsp_o.err <= (req_i.wr && !wr_brake_ok && !wr_inv_ok) || (req_i.rd && !rd_hit);
      rsp_o.rdata <= '0;
      if (req_i.rd) begin
        case (req_i.addr)
          ADDR_BRAKE_CTRL: rsp_o.rdata <= RDATA_W'(brake_mode_reg);
          ADDR_INVERT_CFG: rsp_o.rdata <= RDATA_W'(invert_cfg_reg);
          ADDR_ENC_ABSPOS: rsp_o.rdata <= RDATA_W'(abs_pos_reg);
          default:         rsp_o.rdata <= '0;
        endcase
      end
    end
  end

  apply_blocks_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && brake_mode_reg == BRK_APPLY |=> !brake_release_o)
    else $error("brake released while manual apply");
  release_state_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !rel_allowed && !auto_release_i |=> !brake_release_o)
    else $error("manual release outside allowed states");
  brake_now_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_brake_ok && req_i.wdata == WDATA_W'(BRK_APPLY) ##1 ce_i |=> !brake_release_o)
    else $error("brake setting not applied");
  brake_value_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && req_i.wr && req_i.addr == ADDR_BRAKE_CTRL && req_i.wdata == WDATA_W'(BRK_APPLY)
    |=> brake_mode_reg == BRK_APPLY)
    else $error("apply code not decoded");
  apply_to_rel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    brake_mode_reg == BRK_APPLY |=> brake_mode_reg != BRAKE_MANUAL_CONTROL)
    else $error("direct apply to release accepted");
  di_release_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && brake_mode_reg == BRK_AUTO && !auto_release_i && !di_release |=> !brake_release_o)
    else $error("input released brake without function");
  inv_locked_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stage_enabled_i && !(ce_i && power_on_i) |=> $stable(invert_cfg_reg))
    else $error("inversion changed with stage enabled");
  inv_deferred_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(ce_i && power_on_i) |=> $stable(invert_active_o))
    else $error("inversion applied before power-on");
  inv_value_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && power_on_i |=> invert_active_o == $past(invert_cfg_reg))
    else $error("inversion code not decoded");
  dir_sign_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !target_neg_i && !invert_active_o && !power_on_i |=> move_positive_o)
    else $error("direction wrong for positive target");
  jog_enable_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && jog_pos_in && !jog_neg_in |=> jog_o.jog_pos && jog_o.stage_enable_req)
    else $error("jog input did not enable stage");
  capture_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && enc_state_reg == ENC_WAIT && enc_valid_i && !gear_change_i
    |=> abs_valid_o && abs_pos_reg == $past(pos_mod))
    else $error("start-up position not captured");
  st_modulo_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !enc_multiturn_i |-> pos_mod < ENC_MT_W'(ENC_ST_INCR))
    else $error("singleturn position outside one turn");
  gear_inval_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && gear_change_i |=> !abs_valid_o)
    else $error("position valid after gear change");
  range_reject_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    req_i.wr && req_i.addr == ADDR_INVERT_CFG && req_i.wdata > INVERT_MAX
    |=> $stable(invert_cfg_reg))
    else $error("out-of-range inversion accepted");

  manual_rel_c: cover property (@(posedge clk_i) brake_mode_reg == BRAKE_MANUAL_CONTROL && brake_release_o);
  apply_c: cover property (@(posedge clk_i) brake_mode_reg == BRK_APPLY && stage_enabled_i);
  inv_c: cover property (@(posedge clk_i) invert_active_o && !move_positive_o);
  gear_c: cover property (@(posedge clk_i) enc_state_reg == ENC_RUN && !abs_valid_o);
endmodule

// ===== verilog/bdec_pkg.sv
// Purpose: constants and carrier types of the brake, direction and encoder control
// Assumes: parameter requests arrive on the drive clock from the fieldbus logic
// Notes:   register offsets are parameter addresses, not byte addresses
package bdec_pkg;
  localparam int ADDR_W = 16;
  localparam int WDATA_W = 16;
  localparam int RDATA_W = 32;
  localparam int NUM_DI = 4;

  localparam logic [ADDR_W-1:0] ADDR_INVERT_CFG = 16'h0618;
  localparam logic [ADDR_W-1:0] ADDR_BRAKE_CTRL = 16'h0814;
  localparam logic [ADDR_W-1:0] ADDR_ENC_ABSPOS = 16'h1E1E;

  localparam logic [WDATA_W-1:0] BRAKE_MAX = 16'h0002;
  localparam logic [WDATA_W-1:0] INVERT_MAX = 16'h0001;

  localparam int ENC_ST_INCR = 131072;
  localparam int ENC_MT_REVS = 4096;
  localparam int ENC_ST_W = $clog2(ENC_ST_INCR);
  localparam int ENC_MT_W = ENC_ST_W + $clog2(ENC_MT_REVS);

  localparam logic [3:0] OPST_SWITCH_ON_DIS = 4'h3;
  localparam logic [3:0] OPST_READY_TO_SW = 4'h4;
  localparam logic [3:0] OPST_FAULT = 4'h9;

  typedef enum logic [1:0] {
    BRK_AUTO,
    BRAKE_MANUAL_CONTROL,
    BRK_APPLY
  } bdec_brake_mode_t;

  typedef enum logic [1:0] {
    DIF_NONE,
    DIF_RELEASE_BRAKE,
    DIF_JOG_POS_EN,
    DIF_JOG_NEG_EN
  } bdec_di_func_t;

  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [ADDR_W-1:0]  addr;
    logic [WDATA_W-1:0] wdata;
  } bdec_param_req_t;

  typedef struct packed {
    logic               ack;
    logic               err;
    logic [RDATA_W-1:0] rdata;
  } bdec_param_rsp_t;

  typedef struct packed {
    logic jog_active;
    logic jog_pos;
    logic jog_neg;
    logic stage_enable_req;
  } bdec_jog_t;
endpackage
